// ### core/idt_pkg.sv
package idt_pkg;
   localparam int IDT_WORD_W = 16;
   localparam int IDT_OSC_PER_CYCLE = 4;
   localparam int IDT_TARGET_W = 20;
   // second word of any double-word instruction
   localparam logic [3:0] IDT_SECOND_PREFIX = 4'hF;
   // operand field positions
   localparam int IDT_F_LSB = 0;
   localparam int IDT_F_W = 8;
   localparam int IDT_A_BIT = 8;
   localparam int IDT_D_BIT = 9;
   localparam int IDT_B_LSB = 9;
   localparam int IDT_B_W = 3;
   localparam int IDT_PTR_LSB = 4;
   localparam int IDT_PTR_W = 2;
   localparam int IDT_S_BIT = 0;
   localparam int IDT_MM_LSB = 0;
   localparam int IDT_LOW_W = 12;
   // opcode patterns
   localparam logic [3:0] IDT_NIB_MISC = 4'h0;
   localparam logic [3:0] IDT_NIB_BIT_LO = 4'h7;
   localparam logic [3:0] IDT_NIB_BIT_HI = 4'hB;
   localparam logic [3:0] IDT_NIB_MOVE2 = 4'hC;
   localparam logic [3:0] IDT_NIB_REL = 4'hD;
   localparam logic [3:0] IDT_NIB_BRANCH = 4'hE;
   localparam logic [3:0] IDT_SUB_CTRL = 4'h0;
   localparam logic [3:0] IDT_SUB_BANK = 4'h1;
   localparam logic [3:0] IDT_SUB_LIT = 4'h8;
   localparam logic [7:0] IDT_OP_PTRLOAD = 8'hEE;
   localparam logic [7:0] IDT_OP_JUMP = 8'hEF;
   localparam logic [6:0] IDT_OP_CALL = 7'h76;
   localparam logic [3:0] IDT_COND_LAST = 4'h7;
   localparam logic [13:0] IDT_OP_RET = 14'h0004;
   localparam logic [13:0] IDT_OP_TBLRD = 14'h0002;
   localparam logic [13:0] IDT_OP_TBLWT = 14'h0003;
   localparam int IDT_REL_W = 11;
   localparam int IDT_COND_W = 8;

   typedef enum logic [1:0] {
      IDT_GRP_BYTE,
      IDT_GRP_BIT,
      IDT_GRP_LITERAL,
      IDT_GRP_CONTROL
   } idt_group_e;

   typedef enum logic [2:0] {
      IDT_TBL_NONE,
      IDT_TBL_NOCHG,
      IDT_TBL_POSTINC,
      IDT_TBL_POSTDEC,
      IDT_TBL_PREINC
   } idt_tbl_e;
endpackage

// ### core/idt_fields.sv
module idt_fields (
   input wire logic [idt_pkg::IDT_WORD_W-1:0] word,
   output idt_pkg::idt_group_e group,
   output logic first_double,
   output logic second_alone,
   output logic pc_change,
   output logic [idt_pkg::IDT_F_W-1:0] file_addr,
   output logic dest_file,
   output logic use_bank,
   output logic [idt_pkg::IDT_B_W-1:0] bit_num,
   output logic [7:0] literal,
   output logic [idt_pkg::IDT_PTR_W-1:0] ptr_sel,
   output logic call_fast,
   output idt_pkg::idt_tbl_e tbl_mode,
   output logic [idt_pkg::IDT_TARGET_W-1:0] target
);
   import idt_pkg::*;

   logic [3:0] nib;
   logic [3:0] sub;

   always_comb begin
      nib = word[15:12];
      sub = word[11:8];
      file_addr = word[IDT_F_LSB +: IDT_F_W]; // [RULE15]
      dest_file = word[IDT_D_BIT]; // [RULE6]
      use_bank = word[IDT_A_BIT]; // [RULE13]
      bit_num = word[IDT_B_LSB +: IDT_B_W]; // [RULE14]
      literal = word[7:0];
      ptr_sel = word[IDT_PTR_LSB +: IDT_PTR_W]; // [RULE8]
      call_fast = word[IDT_S_BIT]; // [RULE9]
      first_double = 1'b0;
      second_alone = 1'b0;
      pc_change = 1'b0;
      tbl_mode = IDT_TBL_NONE;
      target = IDT_TARGET_W'(word[7:0]);
      group = IDT_GRP_BYTE; // [RULE5]
      // [RULE2]
      if (nib == IDT_NIB_MISC) begin
         if (sub == IDT_SUB_CTRL) begin
            group = IDT_GRP_CONTROL;
         end else if (sub == IDT_SUB_BANK || sub >= IDT_SUB_LIT) begin
            group = IDT_GRP_LITERAL;
         end
      end else if (nib >= IDT_NIB_BIT_LO && nib <= IDT_NIB_BIT_HI) begin
         group = IDT_GRP_BIT; // [RULE7]
      end else if (nib == IDT_NIB_MOVE2) begin
         first_double = 1'b1; // [RULE3]
      end else if (nib == IDT_NIB_REL) begin
         group = IDT_GRP_CONTROL;
         pc_change = 1'b1;
         target = IDT_TARGET_W'($signed(word[IDT_REL_W-1:0]));
      end else if (nib == IDT_NIB_BRANCH) begin
         group = IDT_GRP_CONTROL;
         if (word[15:8] == IDT_OP_PTRLOAD) begin
            group = IDT_GRP_LITERAL;
            first_double = 1'b1; // [RULE3]
         end else if (word[15:8] == IDT_OP_JUMP || word[15:9] == IDT_OP_CALL) begin
            first_double = 1'b1; // [RULE3]
         end else if (sub <= IDT_COND_LAST) begin
            target = IDT_TARGET_W'($signed(word[IDT_COND_W-1:0]));
         end else begin
            pc_change = 1'b1;
            target = IDT_TARGET_W'($signed(word[IDT_REL_W-1:0]));
         end
      end else if (nib == IDT_SECOND_PREFIX) begin
         group = IDT_GRP_CONTROL;
         second_alone = 1'b1; // [RULE4]
      end
      if (group == IDT_GRP_CONTROL && word[15:2] == IDT_OP_RET) begin
         pc_change = 1'b1;
      end
      // [RULE16]
      if (word[15:2] == IDT_OP_TBLRD || word[15:2] == IDT_OP_TBLWT) begin
         unique case (word[IDT_MM_LSB +: 2])
            2'h0: tbl_mode = IDT_TBL_NOCHG;
            2'h1: tbl_mode = IDT_TBL_POSTINC;
            2'h2: tbl_mode = IDT_TBL_POSTDEC;
            2'h3: tbl_mode = IDT_TBL_PREINC;
         endcase
      end
   end
endmodule

// ### core/idt_decoder.sv
// Contract
// [RULE1] nearly every instruction is one 16-bit word: opcode plus operand fields
// [RULE2] every instruction falls in byte, bit, literal or control group
// [RULE3] four instructions take two words; second word starts with four ones
// [RULE4] a second word executed alone acts as a no-operation
// [RULE5] byte operations decode file address, destination and access select
// [RULE6] destination clear writes working_register, set writes the file register
// [RULE7] bit operations decode file address, bit number and access select
// [RULE8] literal operations decode literal and indirect_pointer select, or nothing
// [RULE9] control operations decode target, call/return mode, table mode, or nothing
// [RULE10] single word takes one cycle, two when test true or counter changes
// [RULE11] double-word instructions finish in two instruction cycles
// [RULE12] one instruction cycle is four oscillator periods
// [RULE13] access bit 0 selects access RAM, 1 uses bank_select_register bank
// [RULE14] bit number is three bits, positions 0 to 7
// [RULE15] file address is 8 bits, or a 2-bit pointer designator
// [RULE16] table mode: no change, post-increment, post-decrement, pre-increment
// [RULE17] extra cycle discards the prefetched word and runs as no-operation
module idt_decoder #(
   parameter int OSC_PER_CYCLE = idt_pkg::IDT_OSC_PER_CYCLE
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [idt_pkg::IDT_WORD_W-1:0] fetch_word,
   input wire logic fetch_valid,
   input wire logic cond_true,
   output logic fetch_ready,
   output logic cycle_strobe,
   output logic flush_prefetch,
   output logic nop_out,
   output logic second_word,
   output idt_pkg::idt_group_e group,
   output logic [idt_pkg::IDT_F_W-1:0] file_addr,
   output logic dest_file,
   output logic use_bank,
   output logic [idt_pkg::IDT_B_W-1:0] bit_num,
   output logic [7:0] literal,
   output logic [idt_pkg::IDT_PTR_W-1:0] ptr_sel,
   output logic call_fast,
   output idt_pkg::idt_tbl_e tbl_mode,
   output logic [idt_pkg::IDT_TARGET_W-1:0] target
);
   import idt_pkg::*;

   // phase counter is 8 bits wide
   if (OSC_PER_CYCLE < 2 || OSC_PER_CYCLE > 256) begin : g_bad_osc
      $error("OSC_PER_CYCLE out of range");
   end

   typedef enum logic [1:0] {
      IDT_ST_EXEC,
      IDT_ST_SECOND,
      IDT_ST_FLUSH
   } idt_state_e;

   localparam logic [7:0] PHASE_LAST = 8'(OSC_PER_CYCLE - 1);

   idt_state_e state_reg, state_next;
   logic [7:0] phase_reg, phase_next;
   logic flush_reg, flush_next;
   logic nop_reg, nop_next;
   logic second_reg, second_next;
   idt_group_e group_reg, group_next;
   logic [IDT_F_W-1:0] faddr_reg, faddr_next;
   logic dest_reg, dest_next;
   logic bank_reg, bank_next;
   logic [IDT_B_W-1:0] bitn_reg, bitn_next;
   logic [7:0] lit_reg, lit_next;
   logic [IDT_PTR_W-1:0] ptr_reg, ptr_next;
   logic fast_reg, fast_next;
   idt_tbl_e tbl_reg, tbl_next;
   logic [IDT_TARGET_W-1:0] tgt_reg, tgt_next;

   idt_group_e d_group;
   logic d_first, d_second, d_pc;
   logic [IDT_F_W-1:0] d_faddr;
   logic d_dest, d_bank, d_fast;
   logic [IDT_B_W-1:0] d_bitn;
   logic [7:0] d_lit;
   logic [IDT_PTR_W-1:0] d_ptr;
   idt_tbl_e d_tbl;
   logic [IDT_TARGET_W-1:0] d_tgt;

   // [RULE1]
   idt_fields u_fields (
      .word(fetch_word),
      .group(d_group),
      .first_double(d_first),
      .second_alone(d_second),
      .pc_change(d_pc),
      .file_addr(d_faddr),
      .dest_file(d_dest),
      .use_bank(d_bank),
      .bit_num(d_bitn),
      .literal(d_lit),
      .ptr_sel(d_ptr),
      .call_fast(d_fast),
      .tbl_mode(d_tbl),
      .target(d_tgt)
   );

   // words are taken only at the last oscillator period of a cycle
   assign cycle_strobe = (phase_reg == PHASE_LAST); // [RULE12]
   assign fetch_ready = cycle_strobe;

   always_comb begin
      phase_next = cycle_strobe ? 8'h00 : phase_reg + 8'h01; // [RULE12]
      state_next = state_reg;
      flush_next = 1'b0;
      nop_next = nop_reg;
      second_next = second_reg;
      group_next = group_reg;
      faddr_next = faddr_reg;
      dest_next = dest_reg;
      bank_next = bank_reg;
      bitn_next = bitn_reg;
      lit_next = lit_reg;
      ptr_next = ptr_reg;
      fast_next = fast_reg;
      tbl_next = tbl_reg;
      tgt_next = tgt_reg;
      if (cycle_strobe) begin
         nop_next = 1'b1;
         second_next = 1'b0;
         unique case (state_reg)
            IDT_ST_EXEC: begin
               // a missing word simply idles one cycle as a no-operation
               if (fetch_valid && !d_second) begin // [RULE4]
                  nop_next = 1'b0;
                  group_next = d_group;
                  faddr_next = d_faddr;
                  dest_next = d_dest;
                  bank_next = d_bank;
                  bitn_next = d_bitn;
                  lit_next = d_lit;
                  ptr_next = d_ptr;
                  fast_next = d_fast;
                  tbl_next = d_tbl;
                  tgt_next = d_tgt;
                  if (d_first) begin
                     state_next = IDT_ST_SECOND; // [RULE3]
                  end else if (d_pc || cond_true) begin
                     state_next = IDT_ST_FLUSH; // [RULE10]
                     flush_next = 1'b1; // [RULE17]
                  end
               end
            end
            IDT_ST_SECOND: begin
               // operand tail; literal and the upper target bits take the second word, other first-word fields stay visible
               if (fetch_valid) begin
                  nop_next = 1'b0;
                  second_next = 1'b1;
                  tgt_next = {fetch_word[IDT_LOW_W-1:0], tgt_reg[7:0]};
                  lit_next = fetch_word[7:0];
                  state_next = IDT_ST_EXEC; // [RULE11]
               end
            end
            IDT_ST_FLUSH: begin
               state_next = IDT_ST_EXEC; // [RULE17]
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= IDT_ST_EXEC;
         phase_reg <= 8'h00;
         flush_reg <= 1'b0;
         nop_reg <= 1'b1;
         second_reg <= 1'b0;
         group_reg <= IDT_GRP_CONTROL;
         faddr_reg <= '0;
         dest_reg <= 1'b0;
         bank_reg <= 1'b0;
         bitn_reg <= '0;
         lit_reg <= 8'h00;
         ptr_reg <= '0;
         fast_reg <= 1'b0;
         tbl_reg <= IDT_TBL_NONE;
         tgt_reg <= '0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         flush_reg <= flush_next;
         nop_reg <= nop_next;
         second_reg <= second_next;
         group_reg <= group_next;
         faddr_reg <= faddr_next;
         dest_reg <= dest_next;
         bank_reg <= bank_next;
         bitn_reg <= bitn_next;
         lit_reg <= lit_next;
         ptr_reg <= ptr_next;
         fast_reg <= fast_next;
         tbl_reg <= tbl_next;
         tgt_reg <= tgt_next;
      end
   end

   assign flush_prefetch = flush_reg;
   assign nop_out = nop_reg;
   assign second_word = second_reg;
   assign group = group_reg;
   assign file_addr = faddr_reg;
   assign dest_file = dest_reg;
   assign use_bank = bank_reg;
   assign bit_num = bitn_reg;
   assign literal = lit_reg;
   assign ptr_sel = ptr_reg;
   assign call_fast = fast_reg;
   assign tbl_mode = tbl_reg;
   assign target = tgt_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   logic exec_take;
   assign exec_take = cycle_strobe && state_reg == IDT_ST_EXEC && fetch_valid;

   cycle_period_a: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe) // [RULE12]
      else $error("instruction cycle not four periods");
   lone_second_a: assert property (exec_take && fetch_word[15:12] == IDT_SECOND_PREFIX |=> nop_out) // [RULE4]
      else $error("lone second word not a nop");
   double_seq_a: assert property (exec_take && d_first |=> state_reg == IDT_ST_SECOND) // [RULE3]
      else $error("double word did not wait for second word");
   double_end_a: assert property (cycle_strobe && state_reg == IDT_ST_SECOND && fetch_valid
      |=> second_word && state_reg == IDT_ST_EXEC) // [RULE11]
      else $error("double word not done in two cycles");
   extra_nop_a: assert property (exec_take && !d_first && !d_second && (d_pc || cond_true)
      |=> flush_prefetch ##1 !flush_prefetch [*3] ##1 nop_out) // [RULE17]
      else $error("extra cycle not flushed as nop");
   single_cycle_a: assert property (exec_take && !d_first && !d_second && !d_pc && !cond_true
      |=> state_reg == IDT_ST_EXEC && !flush_prefetch) // [RULE10]
      else $error("plain single word took extra cycle");
   dest_field_a: assert property (exec_take && !d_second |=> dest_file == $past(fetch_word[IDT_D_BIT])) // [RULE6]
      else $error("destination select mismatch");
   access_field_a: assert property (exec_take && !d_second |=> use_bank == $past(fetch_word[IDT_A_BIT])) // [RULE13]
      else $error("access select mismatch");
   bit_field_a: assert property (exec_take && !d_second && d_group == IDT_GRP_BIT
      |=> group == IDT_GRP_BIT && bit_num == $past(fetch_word[11:9])) // [RULE14]
      else $error("bit number mismatch");
endmodule

// ### test/idt_fetch_model.sv
module idt_fetch_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic fetch_ready,
   input wire logic stall,
   output logic [idt_pkg::IDT_WORD_W-1:0] fetch_word,
   output logic fetch_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [idt_pkg::IDT_WORD_W-1:0] prog [16];
   int idx;
   initial begin
      fetch_word = '0;
      fetch_valid = 1'b0;
   end
   // a word is consumed only when offered and taken; discarded words count too
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         idx <= 0;
      end else if (fetch_ready && fetch_valid) begin
         idx <= idx + 1;
      end
   end
   // stalled bus toggles so a stale word can never pass for a fresh one
   always begin
      @(posedge ref_clk);
      #1;
      if (!stall) begin
         fetch_valid = 1'b1;
         fetch_word = prog[idx];
      end else begin
         fetch_valid = 1'b0;
         fetch_word = ~fetch_word;
      end
   end
endmodule

// ### test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import idt_pkg::*;
   logic ref_clk, resetn, cond_true, stall, fetch_ready, cycle_strobe, flush_prefetch, nop_out;
   logic second_word, dest_file, use_bank, call_fast, fetch_valid;
   logic [15:0] fetch_word;
   logic [7:0] file_addr, literal;
   logic [2:0] bit_num;
   logic [1:0] ptr_sel;
   logic [19:0] target;
   idt_group_e group;
   idt_tbl_e tbl_mode;
   int num_errors, n_compared;

   idt_decoder u_dut (.ref_clk(ref_clk), .resetn(resetn), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
      .cond_true(cond_true), .fetch_ready(fetch_ready), .cycle_strobe(cycle_strobe),
      .flush_prefetch(flush_prefetch), .nop_out(nop_out), .second_word(second_word), .group(group),
      .file_addr(file_addr), .dest_file(dest_file), .use_bank(use_bank), .bit_num(bit_num),
      .literal(literal), .ptr_sel(ptr_sel), .call_fast(call_fast), .tbl_mode(tbl_mode), .target(target));
   idt_fetch_model u_mem (.ref_clk(ref_clk), .resetn(resetn), .fetch_ready(fetch_ready), .stall(stall),
      .fetch_word(fetch_word), .fetch_valid(fetch_valid));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task print_verdict();
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // reset also returns the fetch model to the first program word
   task restart(input logic [15:0] p [$]);
      @(posedge ref_clk);
      #1;
      resetn = 1'b0;
      stall = 1'b0;
      cond_true = 1'b0;
      foreach (p[i]) u_mem.prog[i] = p[i];
      repeat (5) @(posedge ref_clk);
      #1 resetn = 1'b1;
   endtask

   task wait_ready(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (fetch_ready !== 1'b1 && n < 8);
   endtask

   task take();
      int n;
      wait_ready(n);
      check("fetch_ready", fetch_ready, 1'b1);
      @(posedge ref_clk);
      #1;
   endtask

   task t_reset();
      int n;
      restart({16'h0000, 16'h0000});
      check("nop_out", nop_out, 1'b1);
      check("tbl_mode", tbl_mode, IDT_TBL_NONE);
      wait_ready(n);
      check("first_ready", n, 4);
      check("cycle_strobe", cycle_strobe, 1'b1);
      @(posedge ref_clk);
      wait_ready(n);
      check("ready_gap", n, 4);
   endtask

   task t_byte();
      restart({16'h27A5, 16'h2435});
      take();
      check("group", group, IDT_GRP_BYTE);
      check("file_addr", file_addr, 8'hA5);
      check("dest_file", dest_file, 1'b1);
      check("use_bank", use_bank, 1'b1);
      check("nop_out", nop_out, 1'b0);
      take();
      check("file_addr", file_addr, 8'h35);
      check("dest_file", dest_file, 1'b0);
      check("use_bank", use_bank, 1'b0);
   endtask

   task t_bit();
      restart({16'h7B12, 16'hBE00});
      take();
      check("group", group, IDT_GRP_BIT);
      check("bit_num", bit_num, 3'h5);
      check("file_addr", file_addr, 8'h12);
      check("use_bank", use_bank, 1'b1);
      take();
      check("bit_num", bit_num, 3'h7);
      check("use_bank", use_bank, 1'b0);
   endtask

   task t_literal();
      restart({16'h0E3C, 16'hEE20, 16'hF0AB, 16'hF123});
      take();
      check("group", group, IDT_GRP_LITERAL);
      check("literal", literal, 8'h3C);
      take();
      check("ptr_sel", ptr_sel, 2'h2);
      check("second_word", second_word, 1'b0);
      take();
      check("second_word", second_word, 1'b1);
      check("literal", literal, 8'hAB);
      check("ptr_sel", ptr_sel, 2'h2);
      take();
      check("nop_out", nop_out, 1'b1);
      check("second_word", second_word, 1'b0);
      check("literal", literal, 8'hAB);
      check("group", group, IDT_GRP_LITERAL);
   endtask

   task t_control();
      restart({16'hEF34, 16'hF567, 16'hED01, 16'hF000, 16'h0008, 16'h0009, 16'h000A, 16'h000B,
         16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0013});
      take();
      check("group", group, IDT_GRP_CONTROL);
      check("target", target, 20'h00034);
      take();
      check("target", target, 20'h56734);
      check("second_word", second_word, 1'b1);
      check("flush", flush_prefetch, 1'b0);
      take();
      check("call_fast", call_fast, 1'b1);
      take();
      check("target", target, 20'h00001);
      for (int i = 0; i < 8; i++) begin
         take();
         check("tbl_mode", tbl_mode, (i % 4) + 1);
      end
      // return with fast mode changes the counter
      take();
      check("flush", flush_prefetch, 1'b1);
      check("call_fast", call_fast, 1'b1);
      check("tbl_mode", tbl_mode, IDT_TBL_NONE);
   endtask

   task t_branch();
      restart({16'hD7FF, 16'h1234, 16'h2435, 16'h2435, 16'h5555, 16'h2477});
      take();
      check("target", target, 20'hFFFFF);
      check("flush", flush_prefetch, 1'b1);
      @(posedge ref_clk);
      #1;
      check("flush", flush_prefetch, 1'b0);
      take();
      check("nop_out", nop_out, 1'b1);
      take();
      check("nop_out", nop_out, 1'b0);
      cond_true = 1'b1;
      take();
      cond_true = 1'b0;
      check("flush", flush_prefetch, 1'b1);
      take();
      check("nop_out", nop_out, 1'b1);
      check("file_addr", file_addr, 8'h35);
      take();
      check("file_addr", file_addr, 8'h77);
   endtask

   // an empty fetch slot must idle the core without disturbing the fields
   task t_stall();
      restart({16'h2411, 16'h2422});
      take();
      stall = 1'b1;
      take();
      check("nop_out", nop_out, 1'b1);
      check("file_addr", file_addr, 8'h11);
      stall = 1'b0;
      take();
      check("file_addr", file_addr, 8'h22);
   endtask

   initial begin
      resetn = 1'b0;
      cond_true = 1'b0;
      stall = 1'b0;
      num_errors = 0;
      n_compared = 0;
      t_reset();
      t_byte();
      t_bit();
      t_literal();
      t_control();
      t_branch();
      t_stall();
      print_verdict();
   end

   // run needs well under 1000 cycles
   initial begin
      #50000;
      num_errors++;
      print_verdict();
   end
endmodule
